//--- design/meb_pkg.sv
// Package: constants and types shared by both ends of the mapper expansion bus
package meb_pkg;
    localparam logic [7:0]  MEB_PORT_MAPPER   = 8'h2E;
    localparam logic [7:0]  MEB_PORT_MISC     = 8'h0C;
    localparam logic [7:0]  MEB_PORT_CONFIG   = 8'h08;
    localparam logic [15:0] MEB_ROM_END       = 16'h0FFF;
    localparam logic [15:0] MEB_RAM_TWO_START = 16'hC000;
    localparam logic [15:0] MEB_RAM_ONE_START = 16'hE000;
    localparam logic [15:0] MEB_RAM_BASE      = 16'hF000;
    localparam int          MEB_MISC_LOCK_BIT = 5;
    localparam int          MEB_MISC_BREQ_BIT = 6;
    localparam int          MEB_MISC_ROMD_BIT = 7;
    localparam int          MEB_CFG_SLOT1_BIT = 1;
    localparam int          MEB_CFG_SLOT2_BIT = 2;
    localparam logic [7:0]  MEB_MISC_RESET    = 8'h00;
    localparam logic [7:0]  MEB_MAP_RESET     = 8'hFF;
    localparam logic [3:0]  MEB_WAIT_CYCLES   = 4'h2;

    typedef enum logic [2:0] {
        MEB_ARB_CPU   = 3'b001,
        MEB_ARB_SLOT1 = 3'b010,
        MEB_ARB_SLOT2 = 3'b100
    } meb_arb_type;

    typedef enum logic [3:0] {
        MEB_CS_IDLE = 4'b0001,
        MEB_CS_REQ  = 4'b0010,
        MEB_CS_XFER = 4'b0100,
        MEB_CS_REL  = 4'b1000
    } meb_card_state_type;
endpackage : meb_pkg

//--- design/meb_if.sv
// Interface: shared local bus between the 8-bit section and one expansion card
`timescale 1ns/1ns
interface meb_if;
    logic        card_bus_request_n;
    logic        bus_grant_n;
    logic        card_mem_lock_n;
    logic        card_width_select_n;
    logic        card_map_select;
    logic [15:0] card_local_addr;
    logic [7:0]  card_upper_addr;
    logic [15:0] card_data_out;
    logic        card_data_oe;
    logic        card_mem_request_n;
    logic        card_io_request_n;
    logic        card_read_n;
    logic        card_write_n;
    logic        card_wait_n;
    logic        card_present_n;
    logic [7:0]  dev_data_out;

    modport dev (
        input  card_bus_request_n,
        output bus_grant_n,
        input  card_mem_lock_n,
        input  card_width_select_n,
        input  card_map_select,
        input  card_local_addr,
        input  card_upper_addr,
        input  card_data_out,
        input  card_data_oe,
        input  card_mem_request_n,
        input  card_io_request_n,
        input  card_read_n,
        input  card_write_n,
        input  card_wait_n,
        input  card_present_n,
        output dev_data_out
    );
    modport card (
        output card_bus_request_n,
        input  bus_grant_n,
        output card_mem_lock_n,
        output card_width_select_n,
        output card_map_select,
        output card_local_addr,
        output card_upper_addr,
        output card_data_out,
        output card_data_oe,
        output card_mem_request_n,
        output card_io_request_n,
        output card_read_n,
        output card_write_n,
        output card_wait_n,
        output card_present_n,
        input  dev_data_out
    );
endinterface : meb_if

//--- design/meb_device.sv
// 8-bit section: page mapper, region decode, lock mux and two-slot bus arbiter
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
module meb_device
    import meb_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    meb_if.dev               slot1,
    meb_if.dev               slot2,
    input  wire logic [15:0] local_addr,
    input  wire logic [7:0]  local_data,
    input  wire logic        local_mem_request_n,
    input  wire logic        local_io_request_n,
    input  wire logic        local_read_n,
    input  wire logic        local_write_n,
    input  wire logic [1:0]  ram_devices,
    input  wire logic        host_lock_n,
    input  wire logic        host_port_selected,
    output logic [19:0]      main_addr,
    output logic             main_select,
    output logic             main_width16,
    output logic             rom_select,
    output logic             ram_select,
    output logic             mem_lock_n,
    output logic [7:0]       io_read_data,
    output logic             local_wait_n,
    output logic             local_bus_held
);
    logic [7:0]   map_r [16];
    logic [7:0]   misc_r;
    logic [15:0]  ram_start_r;
    logic         cfg_done_r;
    meb_arb_type  arb_r;
    logic [2:0]   s1_req_sync_r, s2_req_sync_r;
    logic [2:0]   s1_lck_sync_r, s2_lck_sync_r;
    logic [2:0]   s1_pres_sync_r, s2_pres_sync_r;
    logic         s1_req, s2_req, s1_lck, s2_lck;

    // Change counts only once stages two and three agree
    function automatic logic filt(input logic [2:0] s, input logic prev);
        return (s[1] == s[2]) ? s[2] : prev;
    endfunction : filt

    logic s1_req_r, s2_req_r, s1_lck_r, s2_lck_r;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s1_req_sync_r <= 3'h7;
            s2_req_sync_r <= 3'h7;
            s1_lck_sync_r <= 3'h7;
            s2_lck_sync_r <= 3'h7;
            s1_pres_sync_r <= 3'h7;
            s2_pres_sync_r <= 3'h7;
            s1_req_r <= 1'b1;
            s2_req_r <= 1'b1;
            s1_lck_r <= 1'b1;
            s2_lck_r <= 1'b1;
        end else begin
            s1_req_sync_r <= {s1_req_sync_r[1:0], slot1.card_bus_request_n};
            s2_req_sync_r <= {s2_req_sync_r[1:0], slot2.card_bus_request_n};
            s1_lck_sync_r <= {s1_lck_sync_r[1:0], slot1.card_mem_lock_n};
            s2_lck_sync_r <= {s2_lck_sync_r[1:0], slot2.card_mem_lock_n};
            s1_pres_sync_r <= {s1_pres_sync_r[1:0], slot1.card_present_n};
            s2_pres_sync_r <= {s2_pres_sync_r[1:0], slot2.card_present_n};
            s1_req_r <= filt(s1_req_sync_r, s1_req_r);
            s2_req_r <= filt(s2_req_sync_r, s2_req_r);
            s1_lck_r <= filt(s1_lck_sync_r, s1_lck_r);
            s2_lck_r <= filt(s2_lck_sync_r, s2_lck_r);
        end
    end
    assign s1_req = ~s1_req_r;
    assign s2_req = ~s2_req_r;
    assign s1_lck = ~s1_lck_r;
    assign s2_lck = ~s2_lck_r;

    // Mapper and latch loads from local I/O writes
    logic io_wr;
    assign io_wr = ~local_io_request_n & ~local_write_n & (arb_r == MEB_ARB_CPU);
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < 16; i++) begin
                map_r[i] <= MEB_MAP_RESET;
            end
        end else if (io_wr && local_addr[7:0] == MEB_PORT_MAPPER) begin
            map_r[local_addr[15:12]] <= local_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            misc_r <= MEB_MISC_RESET;
        end else if (io_wr && local_addr[7:0] == MEB_PORT_MISC) begin
            misc_r <= local_data;
        end
    end

    // Local RAM extent caught on the first clock after reset release
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cfg_done_r  <= 1'b0;
            ram_start_r <= MEB_RAM_BASE;
        end else if (!cfg_done_r) begin
            cfg_done_r <= 1'b1;
            if (ram_devices >= 2'd2) begin
                ram_start_r <= MEB_RAM_TWO_START;
            end else if (ram_devices == 2'd1) begin
                ram_start_r <= MEB_RAM_ONE_START;
            end else begin
                ram_start_r <= MEB_RAM_BASE;
            end
        end
    end

    // Bus arbiter; grant held until the owner drops its request
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            arb_r <= MEB_ARB_CPU;
        end else begin
            case (arb_r)
                MEB_ARB_CPU: begin
                    if (!misc_r[MEB_MISC_BREQ_BIT]) begin
                        arb_r <= MEB_ARB_CPU;
                    end else if (s1_req) begin
                        arb_r <= MEB_ARB_SLOT1;
                    end else if (s2_req) begin
                        arb_r <= MEB_ARB_SLOT2;
                    end
                end
                MEB_ARB_SLOT1: begin
                    if (!s1_req) arb_r <= MEB_ARB_CPU;
                end
                MEB_ARB_SLOT2: begin
                    if (!s2_req) arb_r <= MEB_ARB_CPU;
                end
                default: arb_r <= MEB_ARB_CPU;
            endcase
        end
    end

    // Selected master's bus signals
    logic [15:0] a;
    logic [7:0]  up;
    logic        mreq, use_map, w16, iord;
    always_comb begin
        a       = local_addr;
        up      = 8'h00;
        mreq    = ~local_mem_request_n;
        use_map = 1'b1;
        w16     = 1'b0;
        iord    = ~local_io_request_n & ~local_read_n;
        case (arb_r)
            MEB_ARB_SLOT1: begin
                a       = slot1.card_local_addr;
                up      = slot1.card_upper_addr;
                mreq    = ~slot1.card_mem_request_n;
                use_map = slot1.card_map_select;
                w16     = ~slot1.card_width_select_n;
                iord    = ~slot1.card_io_request_n & ~slot1.card_read_n;
            end
            MEB_ARB_SLOT2: begin
                a       = slot2.card_local_addr;
                up      = slot2.card_upper_addr;
                mreq    = ~slot2.card_mem_request_n;
                use_map = slot2.card_map_select;
                w16     = ~slot2.card_width_select_n;
                iord    = ~slot2.card_io_request_n & ~slot2.card_read_n;
            end
            default: begin
            end
        endcase
    end

    logic in_rom, in_ram;
    assign in_rom = (a <= MEB_ROM_END) & ~misc_r[MEB_MISC_ROMD_BIT];
    assign in_ram = (a >= ram_start_r) | (a >= MEB_RAM_BASE);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            main_addr    <= 20'h0_0000;
            main_select  <= 1'b0;
            main_width16 <= 1'b0;
            rom_select   <= 1'b0;
            ram_select   <= 1'b0;
        end else begin
            rom_select   <= mreq & in_rom;
            ram_select   <= mreq & ~in_rom & in_ram;
            main_select  <= mreq & ~in_rom & ~in_ram;
            main_width16 <= w16;
            if (use_map) begin
                main_addr <= {~map_r[a[15:12]], a[11:0]};
            end else begin
                main_addr <= {up, a[11:0]};
            end
        end
    end

    // Lock: host when its port is selected, else 8-bit side or granted card
    logic z_lock;
    assign z_lock = misc_r[MEB_MISC_LOCK_BIT]
                  | (arb_r == MEB_ARB_SLOT1 & s1_lck)
                  | (arb_r == MEB_ARB_SLOT2 & s2_lck);
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mem_lock_n <= 1'b1;
        end else begin
            mem_lock_n <= host_port_selected ? host_lock_n : ~z_lock;
        end
    end

    // Configuration buffer read and wait merge
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            io_read_data <= 8'h00;
        end else if (iord && a[7:0] == MEB_PORT_CONFIG) begin
            io_read_data <= {5'h00, s2_pres_sync_r[2], s1_pres_sync_r[2], 1'b0};
        end else begin
            io_read_data <= 8'h00;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            local_wait_n   <= 1'b1;
            local_bus_held <= 1'b0;
        end else begin
            local_wait_n   <= slot1.card_wait_n & slot2.card_wait_n;
            local_bus_held <= (arb_r != MEB_ARB_CPU);
        end
    end

    assign slot1.bus_grant_n  = ~(arb_r == MEB_ARB_SLOT1);
    assign slot2.bus_grant_n  = ~(arb_r == MEB_ARB_SLOT2);
    assign slot1.dev_data_out = io_read_data;
    assign slot2.dev_data_out = io_read_data;
endmodule : meb_device

//--- design/meb_card.sv
// Expansion card end: requests the bus, runs one memory or I/O cycle, releases
`timescale 1ns/1ns
module meb_card
    import meb_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    meb_if.card              bus,
    input  wire logic        present,
    input  wire logic        go,
    input  wire logic        go_io,
    input  wire logic        go_write,
    input  wire logic        go_lock,
    input  wire logic        go_wide,
    input  wire logic        go_full_addr,
    input  wire logic [19:0] go_addr,
    input  wire logic [15:0] go_data,
    output logic             busy,
    output logic             done,
    output logic [7:0]       rd_data
);
    meb_card_state_type st_r;
    logic [3:0]  cnt_r;
    logic [2:0]  gnt_sync_r;
    logic        gnt_r;
    logic        io_r, wr_r, lk_r, wide_r, full_r;
    logic [19:0] addr_r;
    logic [15:0] data_r;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            gnt_sync_r <= 3'h7;
            gnt_r      <= 1'b1;
        end else begin
            gnt_sync_r <= {gnt_sync_r[1:0], bus.bus_grant_n};
            if (gnt_sync_r[1] == gnt_sync_r[2]) gnt_r <= gnt_sync_r[2];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st_r    <= MEB_CS_IDLE;
            cnt_r   <= 4'h0;
            io_r    <= 1'b0;
            wr_r    <= 1'b0;
            lk_r    <= 1'b0;
            wide_r  <= 1'b0;
            full_r  <= 1'b0;
            addr_r  <= 20'h0_0000;
            data_r  <= 16'h0000;
            done    <= 1'b0;
            rd_data <= 8'h00;
        end else begin
            done <= 1'b0;
            case (st_r)
                MEB_CS_IDLE: begin
                    if (go) begin
                        io_r   <= go_io;
                        wr_r   <= go_write;
                        lk_r   <= go_lock;
                        wide_r <= go_wide;
                        full_r <= go_full_addr;
                        addr_r <= go_addr;
                        data_r <= go_data;
                        st_r   <= MEB_CS_REQ;
                    end
                end
                MEB_CS_REQ: begin
                    if (!gnt_r) begin
                        st_r  <= MEB_CS_XFER;
                        cnt_r <= MEB_WAIT_CYCLES;
                    end
                end
                MEB_CS_XFER: begin
                    if (cnt_r != 4'h0) begin
                        cnt_r <= cnt_r - 4'h1;
                    end else begin
                        if (!wr_r) rd_data <= bus.dev_data_out;
                        st_r <= MEB_CS_REL;
                    end
                end
                MEB_CS_REL: begin
                    if (gnt_r) begin
                        st_r <= MEB_CS_IDLE;
                        done <= 1'b1;
                    end
                end
                default: st_r <= MEB_CS_IDLE;
            endcase
        end
    end

    logic act;
    assign act = (st_r == MEB_CS_XFER);
    assign busy                    = (st_r != MEB_CS_IDLE);
    assign bus.card_bus_request_n  = ~(st_r == MEB_CS_REQ | st_r == MEB_CS_XFER);
    assign bus.card_mem_lock_n     = ~(act & lk_r);
    assign bus.card_width_select_n = ~(act & wide_r);
    assign bus.card_map_select     = ~full_r;
    assign bus.card_local_addr     = addr_r[15:0];
    assign bus.card_upper_addr     = addr_r[19:12];
    assign bus.card_data_out       = data_r;
    assign bus.card_data_oe        = act & wr_r;
    assign bus.card_mem_request_n  = ~(act & ~io_r);
    assign bus.card_io_request_n   = ~(act & io_r);
    assign bus.card_read_n         = ~(act & ~wr_r);
    assign bus.card_write_n        = ~(act & wr_r);
    assign bus.card_wait_n         = ~(act & (cnt_r != 4'h0));
    assign bus.card_present_n      = ~present;
endmodule : meb_card

//--- tb/meb_properties.sv
// Checker: ownership and strobe properties on the slot 1 link
`timescale 1ns/1ns
module meb_bus_properties (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic card_bus_request_n,
    input wire logic bus_grant_n,
    input wire logic card_mem_request_n,
    input wire logic card_io_request_n,
    input wire logic card_read_n,
    input wire logic card_write_n,
    input wire logic card_data_oe,
    input wire logic card_wait_n
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    wire strobe = !card_mem_request_n || !card_io_request_n;

    chk_grant_needs_req: assert property (
        $fell(bus_grant_n) |-> !card_bus_request_n && !$past(card_bus_request_n, 3))
        else $error("grant without a standing request");
    chk_grant_holds: assert property (
        !bus_grant_n && !card_bus_request_n |=> !bus_grant_n)
        else $error("grant dropped while request still low");
    chk_grant_release: assert property (
        $rose(card_bus_request_n) && !bus_grant_n |-> ##[1:8] bus_grant_n)
        else $error("grant not released after request went away");
    chk_grant_quiet: assert property (
        card_bus_request_n [*8] |-> bus_grant_n)
        else $error("grant present with no request");
    chk_strobe_owned: assert property (
        strobe |-> !bus_grant_n)
        else $error("card strobe without grant");
    chk_strobe_requested: assert property (
        strobe |-> !card_bus_request_n)
        else $error("card strobe without request");
    chk_rw_exclusive: assert property (
        !card_read_n |-> card_write_n)
        else $error("read and write strobes together");
    chk_data_owned: assert property (
        card_data_oe |-> !bus_grant_n)
        else $error("card drives data without grant");
    chk_wait_owned: assert property (
        !card_wait_n |-> !card_bus_request_n)
        else $error("card wait outside its own cycle");
    chk_reset_idle: assert property (disable iff (1'b0)
        srst |=> bus_grant_n && card_bus_request_n)
        else $error("link not idle after reset");
endmodule : meb_bus_properties

//--- tb/tb_mapper_expansion_bus.sv
// Testbench: mapper, region decode, lock mux and two-slot arbitration
`timescale 1ns/1ns
module tb_mapper_expansion_bus
    import meb_pkg::*;
;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [15:0] local_addr = 16'h0000;
    logic [7:0] local_data = 8'h00;
    logic local_mem_request_n = 1'b1, local_io_request_n = 1'b1;
    logic local_read_n = 1'b1, local_write_n = 1'b1;
    logic [1:0] ram_devices = 2'b00;
    logic host_lock_n = 1'b1, host_port_selected = 1'b0;
    logic [19:0] main_addr;
    logic main_select, main_width16, rom_select, ram_select, mem_lock_n;
    logic [7:0] io_read_data;
    logic local_bus_held, local_wait_n;
    logic [7:0] rd1;
    logic go1 = 1'b0, go2 = 1'b0, present1 = 1'b1, present2 = 1'b0;
    logic go_io = 1'b0, go_write = 1'b0, go_lock = 1'b0, go_wide = 1'b0;
    logic go_full_addr = 1'b0;
    logic [19:0] go_addr = 20'h0;
    logic [15:0] go_data = 16'hBEEF;
    logic busy1, busy2, done1, done2;
    logic seen_addr, seen_lock, seen_wide, seen_held, seen_wait;
    int first;
    int bad_count = 0;
    int cmp_count = 0;
    int i;

    meb_if slot1_if();
    meb_if slot2_if();

    meb_device i_meb_device (.ref_clk, .srst, .slot1(slot1_if), .slot2(slot2_if),
        .local_addr, .local_data, .local_mem_request_n, .local_io_request_n,
        .local_read_n, .local_write_n, .ram_devices, .host_lock_n, .host_port_selected,
        .main_addr, .main_select, .main_width16, .rom_select, .ram_select, .mem_lock_n,
        .io_read_data, .local_wait_n, .local_bus_held);
    meb_card i_meb_card (.ref_clk, .srst, .bus(slot1_if), .present(present1), .go(go1),
        .go_io, .go_write, .go_lock, .go_wide, .go_full_addr, .go_addr, .go_data,
        .busy(busy1), .done(done1), .rd_data(rd1));
    meb_card i_meb_card_2 (.ref_clk, .srst, .bus(slot2_if), .present(present2), .go(go2),
        .go_io, .go_write, .go_lock, .go_wide, .go_full_addr, .go_addr, .go_data,
        .busy(busy2), .done(done2), .rd_data());
    meb_bus_properties i_meb_bus_properties (.ref_clk, .srst,
        .card_bus_request_n(slot1_if.card_bus_request_n), .bus_grant_n(slot1_if.bus_grant_n),
        .card_mem_request_n(slot1_if.card_mem_request_n),
        .card_io_request_n(slot1_if.card_io_request_n), .card_read_n(slot1_if.card_read_n),
        .card_write_n(slot1_if.card_write_n), .card_data_oe(slot1_if.card_data_oe),
        .card_wait_n(slot1_if.card_wait_n));

    always #10 ref_clk = ~ref_clk;

    task automatic check(input string name, input logic [19:0] got, input logic [19:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic report_and_stop;
        $display("Counts: %0d mismatches in %0d comparisons", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic do_reset(input logic [1:0] rd);
        @(posedge ref_clk);
        srst <= 1'b1;
        ram_devices <= rd;
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (4) @(posedge ref_clk);
    endtask : do_reset

    // One strobe cycle; outputs are sampled in the following cycle
    task automatic cycle(input logic [15:0] a, input logic [7:0] d, input logic io,
                         input logic wr);
        @(posedge ref_clk);
        local_addr <= a;
        local_data <= d;
        local_mem_request_n <= io;
        local_io_request_n <= !io;
        local_read_n <= wr;
        local_write_n <= !wr;
        @(posedge ref_clk);
        local_mem_request_n <= 1'b1;
        local_io_request_n <= 1'b1;
        local_read_n <= 1'b1;
        local_write_n <= 1'b1;
        @(negedge ref_clk);
    endtask : cycle

    task automatic start(input logic g1, input logic g2, input logic io, input logic wr,
                         input logic lk, input logic wd, input logic fa, input logic [19:0] a);
        @(posedge ref_clk);
        go1 <= g1;
        go2 <= g2;
        go_io <= io;
        go_write <= wr;
        go_lock <= lk;
        go_wide <= wd;
        go_full_addr <= fa;
        go_addr <= a;
        @(posedge ref_clk);
        go1 <= 1'b0;
        go2 <= 1'b0;
    endtask : start

    // Watches both cards to completion and records what reached main memory
    task automatic wait_cards(input logic [19:0] exp);
        int n;
        first = 0;
        seen_addr = 1'b0;
        seen_lock = 1'b0;
        seen_wide = 1'b0;
        seen_held = 1'b0;
        seen_wait = 1'b0;
        for (n = 0; n < 400; n++) begin
            @(negedge ref_clk);
            if (main_select === 1'b1 && main_addr === exp) seen_addr = 1'b1;
            if (mem_lock_n === 1'b0) seen_lock = 1'b1;
            if (main_width16 === 1'b1) seen_wide = 1'b1;
            if (local_bus_held === 1'b1) seen_held = 1'b1;
            if (local_wait_n === 1'b0) seen_wait = 1'b1;
            if (first == 0 && done1 === 1'b1) first = 1;
            else if (first == 0 && done2 === 1'b1) first = 2;
            if (first != 0 && busy1 === 1'b0 && busy2 === 1'b0) break;
        end
        if (n == 400) begin
            bad_count++;
            report_and_stop();
        end
    endtask : wait_cards

    initial begin
        do_reset(2'd0);
        for (i = 0; i < 16; i++) cycle({i[3:0], 4'h0, MEB_PORT_MAPPER}, ~(8'h40 + 8'(i)), 1, 1);
        for (i = 1; i < 15; i++) begin
            cycle({i[3:0], 12'h5A3}, 8'h00, 0, 0);
            check("main_addr", main_addr, {8'h40 + 8'(i), 12'h5A3});
            check("main_select", 20'(main_select), 20'h1);
        end
        cycle(16'h0FFF, 8'h00, 0, 0);
        check("rom_select", 20'({rom_select, main_select}), 20'h2);
        cycle({8'h00, MEB_PORT_MISC}, 8'h80, 1, 1);
        cycle(16'h0FFF, 8'h00, 0, 0);
        check("rom_off_addr", main_addr, {8'h40, 12'hFFF});
        check("rom_off_sel", 20'({rom_select, main_select}), 20'h1);
        cycle(16'hF000, 8'h00, 0, 0);
        check("ram_select", 20'({ram_select, main_select}), 20'h2);
        cycle({8'h00, MEB_PORT_CONFIG}, 8'h00, 1, 0);
        check("config", 20'(io_read_data), 20'h4);
        cycle({8'h00, MEB_PORT_MISC}, 8'hA0, 1, 1);
        repeat (2) @(negedge ref_clk);
        check("lock_own", 20'(mem_lock_n), 20'h0);
        @(posedge ref_clk);
        host_port_selected <= 1'b1;
        repeat (3) @(negedge ref_clk);
        check("lock_host_off", 20'(mem_lock_n), 20'h1);
        @(posedge ref_clk);
        host_lock_n <= 1'b0;
        repeat (3) @(negedge ref_clk);
        check("lock_host_on", 20'(mem_lock_n), 20'h0);
        @(posedge ref_clk);
        host_lock_n <= 1'b1;
        host_port_selected <= 1'b0;
        cycle({8'h00, MEB_PORT_MISC}, 8'h80, 1, 1);
        repeat (2) @(negedge ref_clk);
        check("lock_clear", 20'(mem_lock_n), 20'h1);
        start(1, 0, 0, 1, 1, 1, 0, 20'h0_3123);
        repeat (40) @(negedge ref_clk);
        check("inhibited", 20'({slot1_if.bus_grant_n, busy1}), 20'h3);
        cycle({8'h00, MEB_PORT_MISC}, 8'hC0, 1, 1);
        wait_cards(20'h4_3123);
        check("card_mapped", 20'({seen_addr, seen_held}), 20'h3);
        check("card_lock", 20'({seen_lock, seen_wide}), 20'h3);
        check("card_wait", 20'(seen_wait), 20'h1);
        start(1, 0, 0, 0, 0, 0, 1, 20'h7_6543);
        wait_cards(20'h7_6543);
        check("card_full", 20'({seen_addr, seen_lock, seen_wide}), 20'h4);
        start(1, 1, 1, 1, 0, 0, 0, 20'h0_0070);
        wait_cards(20'h0);
        check("first_slot", 20'(first), 20'h1);
        start(1, 0, 1, 0, 0, 0, 0, {12'h000, MEB_PORT_CONFIG});
        wait_cards(20'h0);
        check("card_config", 20'(rd1), 20'h4);
        for (i = 1; i < 3; i++) begin
            do_reset(2'(i));
            cycle(16'hBFFF, 8'h00, 0, 0);
            check("reset_entry", main_addr, {8'h00, 12'hFFF});
            cycle(16'hD000, 8'h00, 0, 0);
            check("ram_extent", 20'(main_select), 20'(i == 1));
            cycle(16'hE000, 8'h00, 0, 0);
            check("ram_top", 20'(ram_select), 20'h1);
        end
        report_and_stop();
    end
endmodule : tb_mapper_expansion_bus
